//--- core/rtc_indirect_access_interface.sv
// Lock-and-key gate and indirect access path from the processor's special
// function register bus to the clock's internal registers.
// Assumes one bus access per cycle, taken on the clock edge; read data
// appears on sfr_rdata one cycle after the read strobe.
//
// Overview of operation
// - Key A5 then F1 unlocks indirect access.
// - No interval limit between the two keys.
// - Wrong key or locked access disables interface.
// - Unlocked interface allows unlimited indirect accesses.
// - Any key write while unlocked relocks.
// - Key read returns status, never disturbs sequence.
// - Status codes 0..3; disabled ignores key writes.
// - Address register selects the internal target.
// - Data register write starts internal write.
// - Busy bit write starts read into data.
// - Address and data survive device reset.
// - Access takes seven cycles, six when short.
// - Reset enables short strobe; bit 4 switches.
// - Autoread: data read starts next read.
// - Capture and alarm accesses increment the address.
// - Capture bytes 0-3, alarm bytes 8-B.
// - Control 4, oscillator 5-6, pin 7.
// - Load capacitance has sixteen levels.
// - Timer gives alarm and missing-clock events.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_indirect_access_interface #(
    parameter int unsigned MISS_LIMIT = `RTC_MISS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    input wire rtc_pkg::sfr_req_t sfr_req,
    input wire logic rtc_tick,
    output logic [7:0] sfr_rdata,
    output logic [7:0] oscillator_control,
    output logic [3:0] osc_load_cap,
    output logic [7:0] crystal_pin_config,
    output logic timer_running,
    output logic alarm_event,
    output logic missing_event
);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    rtc_pkg::lock_state_t lock_state;
    rtc_pkg::lock_state_t next_lock_state;
    rtc_pkg::op_kind_t op_kind;
    logic [2:0] op_count;
    logic busy;
    logic op_done;
    logic auto_read_enable;
    logic short_strobe;
    logic [3:0] indirect_address_register;
    logic [7:0] indirect_data_register;
    logic [7:0] lock_status_code;
    logic [7:0] internal_rdata;
    logic [7:0] timer_state_control;
    logic [7:0] oscillator_load_config;
    logic [7:0] timer_snapshot_bytes [0:3];
    logic [7:0] wake_match_bytes [0:3];
    logic [31:0] timer_count;
    logic load_pulse;
    logic capture_pulse;
    logic key_wr;
    logic adr_wr;
    logic adr_rd;
    logic dat_wr;
    logic dat_rd;
    logic indirect_touch;
    logic unlocked;
    logic start_read;
    logic start_write;
    logic int_write;
    logic auto_inc;
    rtc_pkg::timer_ctl_t timer_ctl;

    assign key_wr = sfr_req.wr && (sfr_req.addr == `RTC_SFR_KEY);
    assign adr_wr = sfr_req.wr && (sfr_req.addr == `RTC_SFR_ADR);
    assign adr_rd = sfr_req.rd && (sfr_req.addr == `RTC_SFR_ADR);
    assign dat_wr = sfr_req.wr && (sfr_req.addr == `RTC_SFR_DAT);
    assign dat_rd = sfr_req.rd && (sfr_req.addr == `RTC_SFR_DAT);
    assign indirect_touch = adr_wr || adr_rd || dat_wr || dat_rd;
    assign unlocked = (lock_state == rtc_pkg::LK_OPEN);

    ////////////////////////////////////////////////////////////////////////
    // Lock and key gate.

    always_comb begin
        next_lock_state = lock_state;
        if (indirect_touch && !unlocked) begin
            next_lock_state = rtc_pkg::LK_DEAD;
        end else if (key_wr) begin
            case (lock_state)
                rtc_pkg::LK_LOCKED: begin
                    if (sfr_req.wdata == `RTC_KEY_FIRST) begin
                        next_lock_state = rtc_pkg::LK_FIRST;
                    end else begin
                        next_lock_state = rtc_pkg::LK_DEAD;
                    end
                end
                rtc_pkg::LK_FIRST: begin
                    if (sfr_req.wdata == `RTC_KEY_SECOND) begin
                        next_lock_state = rtc_pkg::LK_OPEN;
                    end else begin
                        next_lock_state = rtc_pkg::LK_DEAD;
                    end
                end
                rtc_pkg::LK_OPEN: begin
                    next_lock_state = rtc_pkg::LK_LOCKED;
                end
                rtc_pkg::LK_DEAD: begin
                    next_lock_state = rtc_pkg::LK_DEAD;
                end
                default: begin
                    next_lock_state = rtc_pkg::LK_DEAD;
                end
            endcase
        end
    end

    // Only a system reset leaves the disabled state.
    always_ff @(posedge clk) begin
        if (rst || por) begin
            lock_state <= rtc_pkg::LK_LOCKED;
        end else begin
            lock_state <= next_lock_state;
        end
    end

    always_comb begin
        case (lock_state)
            rtc_pkg::LK_LOCKED: lock_status_code = `RTC_ST_LOCKED;
            rtc_pkg::LK_FIRST: lock_status_code = `RTC_ST_FIRST;
            rtc_pkg::LK_OPEN: lock_status_code = `RTC_ST_OPEN;
            rtc_pkg::LK_DEAD: lock_status_code = `RTC_ST_DEAD;
            default: lock_status_code = `RTC_ST_DEAD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Indirect operation sequencer.

    // A start while busy is dropped; software must poll busy first.
    assign busy = (op_kind != rtc_pkg::OP_IDLE);
    assign op_done = busy && (op_count == 3'h0);
    assign start_read = unlocked && !busy &&
        ((adr_wr && sfr_req.wdata[`RTC_ADR_BUSY_BIT]) ||
        (dat_rd && auto_read_enable));
    assign start_write = unlocked && !busy && dat_wr;
    assign int_write = op_done && (op_kind == rtc_pkg::OP_WRITE);
    assign auto_inc = (indirect_address_register <= `RTC_IA_CAPTURE_LAST) ||
        ((indirect_address_register >= `RTC_IA_ALARM_FIRST) &&
        (indirect_address_register <= `RTC_IA_ALARM_LAST));

    always_ff @(posedge clk) begin
        if (rst || por) begin
            op_kind <= rtc_pkg::OP_IDLE;
            op_count <= 3'h0;
        end else if (start_read || start_write) begin
            op_kind <= start_read ? rtc_pkg::OP_READ : rtc_pkg::OP_WRITE;
            op_count <= short_strobe ? (`RTC_OP_CYC_SHORT - 3'h1) :
                (`RTC_OP_CYC_LONG - 3'h1);
        end else if (op_done) begin
            op_kind <= rtc_pkg::OP_IDLE;
        end else if (busy) begin
            op_count <= op_count - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and data registers.

    // Address and data keep their contents over a device reset; only the
    // power-on clear sets them, so software can resume a byte walk.
    always_ff @(posedge clk) begin
        if (por) begin
            auto_read_enable <= 1'b0;
            short_strobe <= 1'b1;
            indirect_address_register <= `RTC_ADDR_RESET;
        end else if (rst) begin
            short_strobe <= 1'b1;
        end else if (unlocked && adr_wr && !busy) begin
            auto_read_enable <= sfr_req.wdata[`RTC_ADR_AUTOREAD_BIT];
            short_strobe <= sfr_req.wdata[`RTC_ADR_SHORT_BIT];
            indirect_address_register <= sfr_req.wdata[3:0];
        end else if (op_done && auto_inc) begin
            indirect_address_register <=
                indirect_address_register + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (por) begin
            indirect_data_register <= `RTC_BYTE_RESET;
        end else if (rst) begin
            indirect_data_register <= indirect_data_register;
        end else if (start_write) begin
            indirect_data_register <= sfr_req.wdata;
        end else if (op_done && (op_kind == rtc_pkg::OP_READ)) begin
            indirect_data_register <= internal_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal register file.

    // Byte 0 of each group is the least significant byte of the word.
    generate
        for (genvar i = 0; i < 4; i++) begin : g_bytes
            always_ff @(posedge clk) begin
                if (por) begin
                    timer_snapshot_bytes[i] <= `RTC_BYTE_RESET;
                end else if (capture_pulse) begin
                    timer_snapshot_bytes[i] <= timer_count[8*i +: 8];
                end else if (int_write &&
                    (indirect_address_register == 4'(i))) begin
                    timer_snapshot_bytes[i] <= indirect_data_register;
                end
            end
            always_ff @(posedge clk) begin
                if (por) begin
                    wake_match_bytes[i] <= `RTC_BYTE_RESET;
                end else if (int_write && (indirect_address_register ==
                    (`RTC_IA_ALARM_FIRST + 4'(i)))) begin
                    wake_match_bytes[i] <= indirect_data_register;
                end
            end
            assign timer_ctl.load_value[8*i +: 8] = timer_snapshot_bytes[i];
            assign timer_ctl.alarm_value[8*i +: 8] = wake_match_bytes[i];
        end
    endgenerate

    // Load and capture are self-clearing commands; only run is stored.
    always_ff @(posedge clk) begin
        if (por) begin
            timer_state_control <= `RTC_BYTE_RESET;
            oscillator_control <= `RTC_BYTE_RESET;
            oscillator_load_config <= `RTC_BYTE_RESET;
            crystal_pin_config <= `RTC_BYTE_RESET;
            load_pulse <= 1'b0;
            capture_pulse <= 1'b0;
        end else begin
            load_pulse <= 1'b0;
            capture_pulse <= 1'b0;
            if (int_write) begin
                case (indirect_address_register)
                    `RTC_IA_CONTROL: begin
                        timer_state_control <= {
                            indirect_data_register[`RTC_CTRL_RUN_BIT],
                            7'h00};
                        load_pulse <=
                            indirect_data_register[`RTC_CTRL_LOAD_BIT];
                        capture_pulse <=
                            indirect_data_register[`RTC_CTRL_CAPTURE_BIT];
                    end
                    `RTC_IA_OSC_CTRL: begin
                        oscillator_control <= indirect_data_register;
                    end
                    `RTC_IA_OSC_CFG: begin
                        oscillator_load_config <=
                            indirect_data_register;
                    end
                    `RTC_IA_PIN_CFG: begin
                        crystal_pin_config <= indirect_data_register;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign osc_load_cap = oscillator_load_config[3:0];
    assign timer_running = timer_state_control[`RTC_CTRL_RUN_BIT];

    always_comb begin
        case (indirect_address_register)
            4'h0, 4'h1, 4'h2, 4'h3: begin
                internal_rdata =
                    timer_snapshot_bytes[indirect_address_register[1:0]];
            end
            `RTC_IA_CONTROL: internal_rdata = timer_state_control;
            `RTC_IA_OSC_CTRL: internal_rdata = oscillator_control;
            `RTC_IA_OSC_CFG: internal_rdata = oscillator_load_config;
            `RTC_IA_PIN_CFG: internal_rdata = crystal_pin_config;
            4'h8, 4'h9, 4'hA, 4'hB: begin
                internal_rdata =
                    wake_match_bytes[indirect_address_register[1:0]];
            end
            default: internal_rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer core and bus read data.

    assign timer_ctl.run = timer_state_control[`RTC_CTRL_RUN_BIT];
    assign timer_ctl.load = load_pulse;

    rtc_timer_core #(
        .MISS_LIMIT(MISS_LIMIT)
    ) u_timer (
        .clk(clk),
        .rst(por),
        .tick(rtc_tick),
        .ctl(timer_ctl),
        .count(timer_count),
        .alarm_event(alarm_event),
        .missing_event(missing_event)
    );

    // A locked or disabled interface reads back zero from address and data.
    always_ff @(posedge clk) begin
        if (rst || por) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                `RTC_SFR_KEY: sfr_rdata <= lock_status_code;
                `RTC_SFR_ADR: begin
                    sfr_rdata <= unlocked ? {busy, auto_read_enable, 1'b0,
                        short_strobe, indirect_address_register} : 8'h00;
                end
                `RTC_SFR_DAT: begin
                    sfr_rdata <= unlocked ? indirect_data_register : 8'h00;
                end
                default: sfr_rdata <= 8'h00;
            endcase
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

//--- core/rtc_defs.svh
// Constants for the clock's indirect register interface: bus addresses,
// key codes, status codes, internal map, field positions and timing.
// Assumes a 50 MHz system clock; included by bare name where needed.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_SFR_KEY 8'hAE
`define RTC_SFR_ADR 8'hAC
`define RTC_SFR_DAT 8'hAD

`define RTC_KEY_FIRST 8'hA5
`define RTC_KEY_SECOND 8'hF1

`define RTC_ST_LOCKED 8'h00
`define RTC_ST_FIRST 8'h01
`define RTC_ST_OPEN 8'h02
`define RTC_ST_DEAD 8'h03

`define RTC_IA_CAPTURE_LAST 4'h3
`define RTC_IA_CONTROL 4'h4
`define RTC_IA_OSC_CTRL 4'h5
`define RTC_IA_OSC_CFG 4'h6
`define RTC_IA_PIN_CFG 4'h7
`define RTC_IA_ALARM_FIRST 4'h8
`define RTC_IA_ALARM_LAST 4'hB

`define RTC_ADR_BUSY_BIT 7
`define RTC_ADR_AUTOREAD_BIT 6
`define RTC_ADR_SHORT_BIT 4

`define RTC_CTRL_RUN_BIT 7
`define RTC_CTRL_LOAD_BIT 1
`define RTC_CTRL_CAPTURE_BIT 0

`define RTC_OP_CYC_LONG 3'h7
`define RTC_OP_CYC_SHORT 3'h6

`define RTC_BYTE_RESET 8'h00
`define RTC_ADDR_RESET 4'h0

`define RTC_CLK_PERIOD_NS 20
`define RTC_MISS_TIME_NS 1000000
`define RTC_MISS_CYCLES (`RTC_MISS_TIME_NS / `RTC_CLK_PERIOD_NS)

`endif

//--- core/rtc_pkg.sv
// Types shared by the clock interface and its timer core.
// Assumes nothing beyond a SystemVerilog compiler.
package rtc_pkg;

    typedef enum logic [1:0] {
        LK_LOCKED = 2'b00,
        LK_FIRST = 2'b01,
        LK_OPEN = 2'b11,
        LK_DEAD = 2'b10
    } lock_state_t;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b11
    } op_kind_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic run;
        logic load;
        logic [31:0] load_value;
        logic [31:0] alarm_value;
    } timer_ctl_t;

endpackage

//--- core/rtc_timer_core.sv
// 32-bit timer with alarm match and missing-tick detection.
// Assumes rtc_tick is a one-cycle pulse per oscillator period, synchronous
// to clk, and that rst is the power-on clear of the always-on domain.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_timer_core #(
    parameter int unsigned MISS_LIMIT = `RTC_MISS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire rtc_pkg::timer_ctl_t ctl,
    output logic [31:0] count,
    output logic alarm_event,
    output logic missing_event
);

    logic [31:0] gap;
    logic matched;

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 32'h00000000;
        end else if (ctl.load) begin
            count <= ctl.load_value;
        end else if (ctl.run && tick) begin
            count <= count + 32'h00000001;
        end
    end

    // A match raises one pulse; it stays quiet while the value holds.
    always_ff @(posedge clk) begin
        if (rst) begin
            matched <= 1'b0;
            alarm_event <= 1'b0;
        end else begin
            matched <= ctl.run && (count == ctl.alarm_value);
            alarm_event <= ctl.run && (count == ctl.alarm_value) &&
                !matched;
        end
    end

    // The gap counter saturates so a dead oscillator gives one event only.
    always_ff @(posedge clk) begin
        if (rst) begin
            gap <= 32'h00000000;
            missing_event <= 1'b0;
        end else begin
            missing_event <= 1'b0;
            if (tick || !ctl.run) begin
                gap <= 32'h00000000;
            end else if (gap != 32'(MISS_LIMIT)) begin
                gap <= gap + 32'h00000001;
                if (gap == 32'(MISS_LIMIT - 1)) begin
                    missing_event <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- tb/rtc_access_checker_asserts.sv
// Timing and status checks on the ports of the indirect access block.
// Assumes one bus access per cycle and no address write while busy.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_access_checker #(
    parameter int unsigned MISS_LIMIT = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    input wire rtc_pkg::sfr_req_t sfr_req,
    input wire logic rtc_tick,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] oscillator_control,
    input wire logic [3:0] osc_load_cap,
    input wire logic [7:0] crystal_pin_config,
    input wire logic timer_running,
    input wire logic alarm_event,
    input wire logic missing_event
);

logic dat_wr;
logic short_q;
logic [31:0] gap;

assign dat_wr = sfr_req.wr && sfr_req.addr == `RTC_SFR_DAT;

////////////////////////////////////////////////////////////////////////////
// The strobe length follows the last address write; reset forces it on.
always_ff @(posedge clk) begin
    if (rst || por) begin
        short_q <= 1'b1;
    end else if (sfr_req.wr && sfr_req.addr == `RTC_SFR_ADR) begin
        short_q <= sfr_req.wdata[`RTC_ADR_SHORT_BIT];
    end
end

// The tick watch lives in the always-on domain, so rst leaves it alone.
always_ff @(posedge clk) begin
    if (por || rtc_tick) begin
        gap <= 32'h0;
    end else if (gap != 32'hFFFFFFFF) begin
        gap <= gap + 32'h1;
    end
end

////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (rst || por);

a_status_code: assert property (
    $past(sfr_req.rd && sfr_req.addr == `RTC_SFR_KEY)
    |-> sfr_rdata[7:2] == 6'h00) else $error("status code out of range");
a_rdata_cause: assert property (
    sfr_rdata != 8'h00 |-> $past(sfr_req.rd))
    else $error("read data without a read");
a_osc_timing: assert property (
    $changed(oscillator_control)
    |-> (short_q ? $past(dat_wr, 7) : $past(dat_wr, 8)))
    else $error("oscillator write at wrong cycle");
a_pin_timing: assert property (
    $changed(crystal_pin_config)
    |-> (short_q ? $past(dat_wr, 7) : $past(dat_wr, 8)))
    else $error("pin write at wrong cycle");
a_cap_timing: assert property (
    $changed(osc_load_cap) |-> $past(dat_wr, 7) || $past(dat_wr, 8))
    else $error("load cap change without write");
a_run_timing: assert property (
    $changed(timer_running)
    |-> $past(dat_wr, 7) || $past(dat_wr, 8) || $past(dat_wr, 9))
    else $error("run change without write");
a_alarm_pulse: assert property (
    alarm_event |-> timer_running ##1 !alarm_event)
    else $error("alarm pulse malformed");
a_missing_gap: assert property (
    missing_event |-> gap >= MISS_LIMIT - 2 && gap <= MISS_LIMIT + 2)
    else $error("missing event at wrong gap");

endmodule

bind rtc_indirect_access_interface rtc_access_checker #(
    .MISS_LIMIT(MISS_LIMIT)
) chk (
    .clk(clk), .rst(rst), .por(por), .sfr_req(sfr_req),
    .rtc_tick(rtc_tick), .sfr_rdata(sfr_rdata),
    .oscillator_control(oscillator_control), .osc_load_cap(osc_load_cap),
    .crystal_pin_config(crystal_pin_config),
    .timer_running(timer_running), .alarm_event(alarm_event),
    .missing_event(missing_event)
);
`default_nettype wire

//--- tb/sfr_host_model.sv
// Processor core model: single bus writes, reads and busy polling.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module sfr_host_model (
    input wire logic clk,
    input wire logic [7:0] sfr_rdata,
    output var rtc_pkg::sfr_req_t sfr_req
);

initial sfr_req = '0;

// An idle edge follows each strobe so that no signal is set twice at once.
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    sfr_req.wr <= 1'b0;
    @(posedge clk);
endtask

task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    sfr_req.rd <= 1'b0;
    #1 d = sfr_rdata;
    @(posedge clk);
endtask

// Polling replaces fixed instruction spacing, which this bus cannot match.
task automatic poll(output logic [7:0] v);
    for (int i = 0; i < 40; i++) begin
        rd(`RTC_SFR_ADR, v);
        if (v[`RTC_ADR_BUSY_BIT] === 1'b0) begin
            return;
        end
    end
endtask

endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the indirect access block.
// Assumes the host model drives the bus and the bench drives the tick.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module tb;

logic clk = 1'b0;
logic rst = 1'b1;
logic por = 1'b1;
logic rtc_tick = 1'b0;
rtc_pkg::sfr_req_t sfr_req;
logic [7:0] sfr_rdata;
logic [7:0] oscillator_control;
logic [7:0] crystal_pin_config;
logic [3:0] osc_load_cap;
logic timer_running;
logic alarm_event;
logic missing_event;
logic [7:0] v;
int num_errors = 0;
int comparisons = 0;
int alarms = 0;
int misses = 0;

always #10 clk = ~clk;

always @(posedge clk) begin
    if (alarm_event === 1'b1) alarms <= alarms + 1;
    if (missing_event === 1'b1) misses <= misses + 1;
end

rtc_indirect_access_interface #(.MISS_LIMIT(20)) uut (
    .clk(clk), .rst(rst), .por(por), .sfr_req(sfr_req),
    .rtc_tick(rtc_tick), .sfr_rdata(sfr_rdata),
    .oscillator_control(oscillator_control), .osc_load_cap(osc_load_cap),
    .crystal_pin_config(crystal_pin_config),
    .timer_running(timer_running), .alarm_event(alarm_event),
    .missing_event(missing_event)
);

sfr_host_model host (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req));

////////////////////////////////////////////////////////////////////////////
task automatic check(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", n, e, s);
    end
endtask

task automatic expect_rd(input logic [7:0] a, input logic [7:0] e,
                         input string n);
    logic [7:0] d;
    host.rd(a, d);
    check(n, d, e);
endtask

task automatic summarize;
    if (num_errors == 0 && comparisons > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask

task automatic tick_n(input int n);
    repeat (n) begin
        rtc_tick <= 1'b1;
        @(posedge clk);
        rtc_tick <= 1'b0;
        repeat (4) @(posedge clk);
    end
endtask

////////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    expect_rd(`RTC_SFR_KEY, `RTC_ST_LOCKED, "status");
endtask

task automatic t_unlock;
    host.wr(`RTC_SFR_KEY, `RTC_KEY_FIRST);
    expect_rd(`RTC_SFR_KEY, `RTC_ST_FIRST, "status");
    repeat (10) @(posedge clk);
    expect_rd(`RTC_SFR_KEY, `RTC_ST_FIRST, "status");
    host.wr(`RTC_SFR_KEY, `RTC_KEY_SECOND);
    expect_rd(`RTC_SFR_KEY, `RTC_ST_OPEN, "status");
    // Reading the address while locked would disable the interface.
    expect_rd(`RTC_SFR_ADR, 8'h10, "address");
endtask

task automatic t_regs;
    logic [7:0] vals [3] = '{8'h5A, 8'h0C, 8'h3C};
    for (int i = 0; i < 3; i++) begin
        host.wr(`RTC_SFR_ADR, 8'h15 + 8'(i));
        host.wr(`RTC_SFR_DAT, vals[i]);
        host.poll(v);
        host.wr(`RTC_SFR_ADR, 8'h95 + 8'(i));
        host.poll(v);
        expect_rd(`RTC_SFR_DAT, vals[i], "readback");
    end
    check("osc control", oscillator_control, 8'h5A);
    check("load cap", {4'h0, osc_load_cap}, 8'h0C);
    check("pin config", crystal_pin_config, 8'h3C);
endtask

task automatic t_timed(input logic [7:0] a, input logic [7:0] nv,
                       input logic [7:0] old, input int n);
    host.wr(`RTC_SFR_ADR, a);
    host.wr(`RTC_SFR_DAT, nv);
    repeat (n) @(posedge clk);
    #1 check("before done", oscillator_control, old);
    @(posedge clk);
    #1 check("at done", oscillator_control, nv);
    @(posedge clk);
endtask

task automatic t_alarm;
    int m;
    host.wr(`RTC_SFR_ADR, 8'h18);
    for (int i = 0; i < 4; i++) begin
        host.wr(`RTC_SFR_DAT, i == 0 ? 8'h03 : 8'h00);
        host.poll(v);
    end
    host.wr(`RTC_SFR_ADR, 8'hD8);
    for (int i = 0; i < 4; i++) begin
        host.poll(v);
        expect_rd(`RTC_SFR_DAT, i == 0 ? 8'h03 : 8'h00, "alarm");
    end
    host.poll(v);
    check("address", v, 8'h5C);
    host.wr(`RTC_SFR_ADR, 8'h10);
    for (int i = 0; i < 5; i++) begin
        host.wr(`RTC_SFR_DAT, i == 4 ? 8'h82 : 8'h00);
        host.poll(v);
    end
    check("running", {7'h0, timer_running}, 8'h01);
    tick_n(2);
    check("alarms", 8'(alarms), 8'h00);
    tick_n(1);
    check("alarms", 8'(alarms), 8'h01);
    m = misses;
    repeat (40) @(posedge clk);
    check("misses", 8'(misses), 8'(m + 1));
    host.wr(`RTC_SFR_DAT, 8'h81);
    host.poll(v);
    host.wr(`RTC_SFR_ADR, 8'hD0);
    for (int i = 0; i < 4; i++) begin
        host.poll(v);
        expect_rd(`RTC_SFR_DAT, i == 0 ? 8'h03 : 8'h00, "timer");
    end
endtask

task automatic t_lock;
    host.poll(v);
    host.wr(`RTC_SFR_KEY, 8'h00);
    expect_rd(`RTC_SFR_KEY, `RTC_ST_LOCKED, "status");
    expect_rd(`RTC_SFR_ADR, 8'h00, "locked read");
    expect_rd(`RTC_SFR_KEY, `RTC_ST_DEAD, "status");
    host.wr(`RTC_SFR_KEY, `RTC_KEY_FIRST);
    expect_rd(`RTC_SFR_KEY, `RTC_ST_DEAD, "status");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    expect_rd(`RTC_SFR_KEY, `RTC_ST_LOCKED, "status");
    host.wr(`RTC_SFR_KEY, `RTC_KEY_FIRST);
    host.wr(`RTC_SFR_KEY, `RTC_KEY_SECOND);
    expect_rd(`RTC_SFR_ADR, 8'h54, "kept address");
    expect_rd(`RTC_SFR_DAT, 8'h80, "kept data");
    host.poll(v);
    host.wr(`RTC_SFR_KEY, 8'h00);
    host.wr(`RTC_SFR_KEY, `RTC_KEY_FIRST);
    host.wr(`RTC_SFR_KEY, 8'h77);
    expect_rd(`RTC_SFR_KEY, `RTC_ST_DEAD, "status");
endtask

////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
end

initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    t_reset();
    t_unlock();
    t_regs();
    t_timed(8'h15, 8'hA1, 8'h5A, 4);
    t_timed(8'h05, 8'hB2, 8'hA1, 5);
    t_alarm();
    t_lock();
    summarize();
end

endmodule
`default_nettype wire
